// File: verilog/pwm_pkg.sv
/*
  Constants shared by the waveform timer: register offsets, field positions,
  reset values and count-source codes.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
`default_nettype none
package pwm_pkg;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned ADDR_W = 5;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_IOCTRL = 5'h04;
  localparam logic [4:0] OFF_PRESCALE = 5'h08;
  localparam logic [4:0] OFF_FIRST = 5'h0c;
  localparam logic [4:0] OFF_SECOND = 5'h10;
  localparam logic [4:0] OFF_PINROUTE = 5'h14;
  localparam logic [4:0] OFF_PORTLATCH = 5'h18;
  // Control register fields
  localparam int unsigned BIT_RUN = 0;
  localparam int unsigned BIT_HALT = 1;
  localparam int unsigned BIT_ACTIVE = 2;
  // I/O control register fields
  localparam int unsigned BIT_POL = 0;
  localparam int unsigned BIT_SRC = 1;
  localparam int unsigned BIT_CSEL_LO = 2;
  // Pin routing and port latch fields
  localparam int unsigned BIT_PIN = 0;
  localparam int unsigned BIT_LATCH = 0;
  // Reset values
  localparam logic [7:0] RST_RELOAD = 8'hff;
  // Count-source select codes
  localparam logic [1:0] CSEL_F1 = 2'h0;
  localparam logic [1:0] CSEL_F2 = 2'h1;
  localparam logic [1:0] CSEL_F8 = 2'h2;
  localparam logic [1:0] CSEL_EXT = 2'h3;
  localparam logic [2:0] DIV_F2_MASK = 3'h1;
  localparam logic [2:0] DIV_F8_MASK = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwm_pkg
`default_nettype wire

// File: verilog/count_source_sel.sv
/*
  Count-source selector: turns the chosen source into a one-cycle enable.
  Assumes the neighbouring timer's underflow arrives as a one-cycle pulse on aclk.
*/
`default_nettype none
module count_source_sel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection
  input wire logic [1:0] sel,
  input wire logic ext_underflow,
  // Enable out
  output logic tick
);
  logic [2:0] div_r;

  // Free-running divider; f2 and f8 are enables, not clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  always_comb begin
    unique case (sel)
      pwm_pkg::CSEL_F1: tick = 1'b1; // [R1]
      pwm_pkg::CSEL_F2: tick = (div_r & pwm_pkg::DIV_F2_MASK) == pwm_pkg::DIV_F2_MASK; // [R1]
      pwm_pkg::CSEL_F8: tick = (div_r & pwm_pkg::DIV_F8_MASK) == pwm_pkg::DIV_F8_MASK; // [R1]
      pwm_pkg::CSEL_EXT: tick = ext_underflow; // [R1]
    endcase
  end
endmodule : count_source_sel
`default_nettype wire

// File: verilog/reload_down_counter.sv
/*
  Reloadable down-counter: loads on request, decrements on tick and reloads
  on underflow. Underflow is a combinational flag for the cycle of the tick.
  Assumes load and tick come from the same clock domain.
*/
`default_nettype none
module reload_down_counter #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] reload_val,
  // State
  output logic [W-1:0] count,
  output logic underflow
);
  logic [W-1:0] count_r;

  assign underflow = tick && (count_r == '0);
  assign count = count_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '1;
    end else if (load) begin
      count_r <= load_val;
    end else if (underflow) begin
      count_r <= reload_val; // [R2]
    end else if (tick) begin
      count_r <= count_r - 1'b1; // [R2]
    end
  end
endmodule : reload_down_counter
`default_nettype wire

// File: verilog/timer_waveform_gen.sv
/*
  Programmable waveform timer: 8-bit prescaler feeding an 8-bit counter that
  alternates between a first and a second phase reload, toggling a pulse pin
  at each underflow, with an AXI4-Lite register slave.
  Assumes a single aclk domain; the neighbour underflow is a one-cycle pulse.
*/
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
// How it works
// [R1] Prescaler clocked by f1, f2, f8 or neighbour
// [R2] Count down, reload first/second alternately on underflow
// [R3] Phase lengths are (n+1)(m+1) and (n+1)(p+1)
// [R4] Writing run bit one starts counting
// [R5] Writing run bit zero stops counting
// [R6] Writing halt bit one stops immediately
// [R7] Halt resets reloads to ff and run bits
// [R8] Interrupt after second-phase underflow, with output change
// [R9] Pulse pin inverts at every counter underflow
// [R10] Start always begins with first phase
// [R11] Pin is plain output or pulse output
// [R12] Prescale and first registers read live counts
// [R13] First register readable during second phase
// [R14] Stopped writes load reload and counter
// [R15] Running writes load reload register only
// [R16] New reloads apply from next first phase
// [R17] Software writes second then first register
// [R18] Polarity bit selects phase output levels
// [R19] Source bit picks pulse or port latch
// [R20] Source change taken at start or interrupt
// [R21] Pin-select bit routes pulse to one pin
// [R22] Counter ticks per prescaler underflow; prescaler reloads
`default_nettype none
module timer_waveform_gen (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [pwm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [pwm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Neighbouring timer
  input wire logic neighbour_underflow,
  // Pins and interrupt
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic timer_irq
);
  localparam int unsigned W = pwm_pkg::CNT_W;
  typedef enum logic {PH_FIRST, PH_SECOND} phase_e;

  // Bus state
  logic aw_have_r, w_have_r;
  logic [pwm_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  // Software-visible settings
  logic count_run_bit_r;
  logic output_polarity_select_r, output_source_select_r, output_pin_choice_r, port_latch_r;
  logic [1:0] csel_r;
  logic [W-1:0] prescale_reload_reg_r, first_phase_reload_reg_r, second_phase_reload_reg_r;
  // Values in use by the waveform
  logic [W-1:0] act_pre_r, act_first_r, act_second_r;
  logic pend_r, src_eff_r;
  phase_e phase_r;

  logic wr_fire, wr_lane, rd_fire;
  logic halt_wr, run_wr, pre_wr, first_wr, second_wr;
  logic cs_tick, pre_tick, pre_uf, main_tick, main_uf;
  logic [W-1:0] pre_count, main_count, main_reload;
  logic pre_load, main_load;
  logic [W-1:0] pre_load_val, main_load_val, wbyte;
  logic start_evt, sec_uf;
  logic pulse_lvl, pin_val;

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_lane = wr_fire && w_strb_r[0];
  assign wbyte = w_data_r[W-1:0];
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign halt_wr = wr_lane && aw_addr_r == pwm_pkg::OFF_CTRL && w_data_r[pwm_pkg::BIT_HALT];
  assign run_wr = wr_lane && aw_addr_r == pwm_pkg::OFF_CTRL && !w_data_r[pwm_pkg::BIT_HALT];
  assign pre_wr = wr_lane && aw_addr_r == pwm_pkg::OFF_PRESCALE;
  assign first_wr = wr_lane && aw_addr_r == pwm_pkg::OFF_FIRST;
  assign second_wr = wr_lane && aw_addr_r == pwm_pkg::OFF_SECOND;
  assign start_evt = run_wr && w_data_r[pwm_pkg::BIT_RUN] && !count_run_bit_r;

  // AXI write channels are taken independently, answered when both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r[1:0] != 2'h0 || aw_addr_r > pwm_pkg::OFF_PORTLATCH) ?
                       pwm_pkg::RESP_SLVERR : pwm_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end
    end
  end

  // AXI read: one outstanding, data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pwm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= pwm_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0;
        unique case (s_axi_araddr)
          pwm_pkg::OFF_CTRL: begin
            s_axi_rdata[pwm_pkg::BIT_RUN] <= count_run_bit_r;
            s_axi_rdata[pwm_pkg::BIT_ACTIVE] <= count_run_bit_r;
          end
          pwm_pkg::OFF_IOCTRL: begin
            s_axi_rdata[pwm_pkg::BIT_POL] <= output_polarity_select_r;
            s_axi_rdata[pwm_pkg::BIT_SRC] <= output_source_select_r;
            s_axi_rdata[pwm_pkg::BIT_CSEL_LO +: 2] <= csel_r;
          end
          pwm_pkg::OFF_PRESCALE: s_axi_rdata[W-1:0] <= pre_count; // [R12]
          pwm_pkg::OFF_FIRST: s_axi_rdata[W-1:0] <= main_count; // [R12] [R13]
          pwm_pkg::OFF_SECOND: s_axi_rdata[W-1:0] <= second_phase_reload_reg_r;
          pwm_pkg::OFF_PINROUTE: s_axi_rdata[pwm_pkg::BIT_PIN] <= output_pin_choice_r;
          pwm_pkg::OFF_PORTLATCH: s_axi_rdata[pwm_pkg::BIT_LATCH] <= port_latch_r;
          default: s_axi_rresp <= pwm_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Run control; halt beats any run value in the same write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_run_bit_r <= 1'b0;
    end else if (halt_wr) begin
      count_run_bit_r <= 1'b0; // [R6] [R7]
    end else if (run_wr) begin
      count_run_bit_r <= w_data_r[pwm_pkg::BIT_RUN]; // [R4] [R5]
    end
  end

  // Plain settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_polarity_select_r <= 1'b0;
      output_source_select_r <= 1'b0;
      csel_r <= pwm_pkg::CSEL_F1;
      output_pin_choice_r <= 1'b0;
      port_latch_r <= 1'b0;
    end else if (wr_lane) begin
      if (aw_addr_r == pwm_pkg::OFF_IOCTRL) begin
        output_polarity_select_r <= w_data_r[pwm_pkg::BIT_POL]; // [R18]
        output_source_select_r <= w_data_r[pwm_pkg::BIT_SRC]; // [R19]
        csel_r <= w_data_r[pwm_pkg::BIT_CSEL_LO +: 2]; // [R1]
      end
      if (aw_addr_r == pwm_pkg::OFF_PINROUTE) begin
        output_pin_choice_r <= w_data_r[pwm_pkg::BIT_PIN]; // [R21]
      end
      if (aw_addr_r == pwm_pkg::OFF_PORTLATCH) begin
        port_latch_r <= w_data_r[pwm_pkg::BIT_LATCH]; // [R11]
      end
    end
  end

  // Software reload registers
  always_ff @(posedge aclk) begin
    if (!aresetn || halt_wr) begin
      prescale_reload_reg_r <= pwm_pkg::RST_RELOAD; // [R7]
      first_phase_reload_reg_r <= pwm_pkg::RST_RELOAD; // [R7]
      second_phase_reload_reg_r <= pwm_pkg::RST_RELOAD; // [R7]
    end else begin
      if (pre_wr) prescale_reload_reg_r <= wbyte;
      if (first_wr) first_phase_reload_reg_r <= wbyte;
      if (second_wr) second_phase_reload_reg_r <= wbyte;
    end
  end

  // Values in use; while running they wait for the next first phase after a first-register write
  always_ff @(posedge aclk) begin
    if (!aresetn || halt_wr) begin
      act_pre_r <= pwm_pkg::RST_RELOAD;
      act_first_r <= pwm_pkg::RST_RELOAD;
      act_second_r <= pwm_pkg::RST_RELOAD;
      pend_r <= 1'b0;
    end else if (!count_run_bit_r) begin
      if (pre_wr) act_pre_r <= wbyte; // [R14]
      if (first_wr) act_first_r <= wbyte; // [R14]
      if (second_wr) act_second_r <= wbyte; // [R14]
      pend_r <= 1'b0;
    end else begin
      if (sec_uf && pend_r) begin
        act_pre_r <= prescale_reload_reg_r; // [R16]
        act_first_r <= first_phase_reload_reg_r; // [R16]
        act_second_r <= second_phase_reload_reg_r; // [R16]
      end
      // A write in the same cycle as the switch stays pending
      if (first_wr) begin
        pend_r <= 1'b1; // [R15] [R17]
      end else if (sec_uf) begin
        pend_r <= 1'b0;
      end
    end
  end

  count_source_sel u_csel (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(csel_r),
    .ext_underflow(neighbour_underflow),
    .tick(cs_tick)
  );

  assign pre_tick = count_run_bit_r && cs_tick;
  assign pre_load = halt_wr || (pre_wr && !count_run_bit_r); // [R14] [R15]
  assign pre_load_val = halt_wr ? pwm_pkg::RST_RELOAD : wbyte;
  // Prescaler reloads from the value in use at each of its underflows
  reload_down_counter #(.W(W)) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(pre_tick),
    .load(pre_load),
    .load_val(pre_load_val),
    .reload_val(act_pre_r), // [R22]
    .count(pre_count),
    .underflow(pre_uf)
  );

  assign main_tick = pre_uf; // [R22] [R3]
  assign main_load = halt_wr || (first_wr && !count_run_bit_r); // [R14] [R15]
  assign main_load_val = halt_wr ? pwm_pkg::RST_RELOAD : wbyte;
  // Pending updates land on the reload that opens the next first phase
  assign main_reload = (phase_r == PH_FIRST) ? act_second_r :
                       (pend_r ? first_phase_reload_reg_r : act_first_r); // [R2] [R16]
  reload_down_counter #(.W(W)) u_main (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(main_tick),
    .load(main_load),
    .load_val(main_load_val),
    .reload_val(main_reload),
    .count(main_count),
    .underflow(main_uf)
  );

  assign sec_uf = main_uf && phase_r == PH_SECOND;

  // Phase alternates on every underflow, always restarting at the first phase
  always_ff @(posedge aclk) begin
    if (!aresetn || halt_wr) begin
      phase_r <= PH_FIRST;
    end else if (start_evt) begin
      phase_r <= PH_FIRST; // [R10]
    end else if (main_uf) begin
      phase_r <= (phase_r == PH_FIRST) ? PH_SECOND : PH_FIRST; // [R2] [R9]
    end
  end

  // Output source only takes effect at start or at the interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_eff_r <= 1'b0;
    end else if (start_evt || sec_uf) begin
      src_eff_r <= output_source_select_r; // [R20]
    end
  end

  // Polarity zero drives high in the first phase and low in the second
  assign pulse_lvl = (phase_r == PH_SECOND) ^ !output_polarity_select_r; // [R18] [R9]
  assign pin_val = src_eff_r ? port_latch_r : pulse_lvl; // [R19] [R11]

  // Interrupt comes on the edge after the underflow, the pin change one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
      pin_a_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      timer_irq <= sec_uf; // [R8]
      pin_a_out <= !output_pin_choice_r && pin_val; // [R21]
      pin_a_oe <= !output_pin_choice_r; // [R21]
      pin_b_out <= output_pin_choice_r && pin_val; // [R21]
      pin_b_oe <= output_pin_choice_r; // [R21]
    end
  end
endmodule : timer_waveform_gen
`default_nettype wire

// File: tb/timer_waveform_monitor.sv
/*
  Port checks on the waveform timer: bus handshakes, pin drive, interrupt.
  Assumes one aclk domain and a synchronous active-low reset.
*/
`default_nettype none
module timer_waveform_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and interrupt
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_irq_one_pulse: assert property (timer_irq |=> !timer_irq)
    else $error("irq longer than one cycle");
  a_pin_one_driver: assert property (!(pin_a_oe && pin_b_oe))
    else $error("both pins driven");
  a_idle_pin_low: assert property (!pin_b_oe |-> !pin_b_out)
    else $error("undriven pin not low");
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_b_release: assert property (s_b_done |=> !s_axi_bvalid)
    else $error("bvalid held after accept");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after accept");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
endmodule : timer_waveform_monitor
`default_nettype wire

// File: tb/pin_load.sv
/*
  Load on the two pulse pins: a pull-down on each, and run-length capture
  of the combined level. Assumes one pin is driven at a time, on aclk.
*/
`default_nettype none
module pin_load (
  // Clock
  input wire logic aclk,
  // Pin drive
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // Observation
  output logic lvl_a,
  output logic lvl_b,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len,
  output logic [15:0] rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic [15:0] run = 16'h0000;
  // Released pins fall to the pull-down, never hold the last value
  assign lvl_a = a_oe ? a_out : 1'b0;
  assign lvl_b = b_oe ? b_out : 1'b0;
  initial begin
    hi_len = 16'h0000;
    lo_len = 16'h0000;
    rises = 16'h0000;
  end
  always @(posedge aclk) begin
    prev <= lvl_a | lvl_b;
    if ((lvl_a | lvl_b) != prev) begin
      run <= 16'h0001;
      if (prev) hi_len <= run;
      else lo_len <= run;
      if (lvl_a | lvl_b) rises <= rises + 16'h0001;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule : pin_load
`default_nettype wire

// File: tb/timer_waveform_gen_tb.sv
/*
  Self-checking bench for the waveform timer: AXI4-Lite master tasks and
  one task per scenario, with a pin load model on the pulse pins.
  Assumes the register map and bus latencies of the designer's note.
*/
`default_nettype none
module timer_waveform_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, neighbour_underflow = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, timer_irq, lvl_a, lvl_b;
  logic [15:0] hi_len, lo_len, rises;
  logic [1:0] nb_div = 2'h0;
  int num_errors = 0;
  int check_count = 0;
  int irq_count = 0;

  always #50 aclk = ~aclk;
  // Neighbour underflows every third cycle, so that source divides by 3
  always @(posedge aclk) begin
    nb_div <= (nb_div == 2'h2) ? 2'h0 : nb_div + 2'h1;
    neighbour_underflow <= (nb_div == 2'h2);
    if (timer_irq === 1'b1) irq_count <= irq_count + 1;
  end

  timer_waveform_gen u_dut (.*);
  pin_load u_load (.aclk(aclk), .a_out(pin_a_out), .a_oe(pin_a_oe), .b_out(pin_b_out), .b_oe(pin_b_oe),
    .lvl_a(lvl_a), .lvl_b(lvl_b), .hi_len(hi_len), .lo_len(lo_len), .rises(rises));

  task automatic close_out();
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = pwm_pkg::RESP_OKAY);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 40);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 40);
    d = s_axi_rdata;
    r = (s_axi_rvalid === 1'b1) ? s_axi_rresp : 2'h3;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er = pwm_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rc

  // Loads written while stopped, then start
  task automatic setup(input logic [7:0] n, input logic [7:0] p, input logic [7:0] m, input logic [3:0] io);
    wr(pwm_pkg::OFF_PRESCALE, {24'h0, n});
    wr(pwm_pkg::OFF_SECOND, {24'h0, p});
    wr(pwm_pkg::OFF_FIRST, {24'h0, m});
    wr(pwm_pkg::OFF_IOCTRL, {28'h0, io});
    wr(pwm_pkg::OFF_CTRL, 32'h1);
  endtask : setup

  // Skips the first rise, which may be the start itself
  task automatic meas(output logic [15:0] hi, output logic [15:0] lo);
    logic [15:0] r0;
    int i0, k;
    r0 = rises;
    k = 0;
    while (rises < r0 + 16'h1 && k < 4000) begin @(posedge aclk); k++; end
    i0 = irq_count;
    while (rises < r0 + 16'h3 && k < 4000) begin @(posedge aclk); k++; end
    chk(32'(irq_count - i0), 32'h2);
    hi = hi_len;
    lo = lo_len;
  endtask : meas

  task automatic t_regs();
    rc(pwm_pkg::OFF_PRESCALE, 32'hff);
    rc(pwm_pkg::OFF_FIRST, 32'hff);
    rc(pwm_pkg::OFF_SECOND, 32'hff);
    rc(pwm_pkg::OFF_CTRL, 32'h0);
    rc(5'h1c, 32'h0, pwm_pkg::RESP_SLVERR);
    wr(5'h1c, 32'h1, pwm_pkg::RESP_SLVERR);
  endtask : t_regs

  task automatic t_sources();
    logic [15:0] hi, lo;
    int dv[4] = '{1, 2, 8, 3};
    for (int s = 0; s < 4; s++) begin
      setup(8'h01, 8'h01, 8'h02, {s[1:0], 2'h0});
      meas(hi, lo);
      chk({16'h0, hi}, 32'(6 * dv[s]));
      chk({16'h0, lo}, 32'(4 * dv[s]));
      wr(pwm_pkg::OFF_CTRL, 32'h0);
    end
  endtask : t_sources

  task automatic t_polarity();
    logic [15:0] hi, lo;
    setup(8'h00, 8'h01, 8'h03, 4'h1);
    meas(hi, lo);
    chk({16'h0, hi}, 32'h2);
    chk({16'h0, lo}, 32'h4);
    wr(pwm_pkg::OFF_CTRL, 32'h0);
  endtask : t_polarity

  task automatic t_update();
    logic [15:0] hi, lo, r0;
    logic [31:0] d;
    logic [1:0] r;
    int k;
    setup(8'h01, 8'h03, 8'h09, 4'h0);
    meas(hi, lo);
    rd(pwm_pkg::OFF_PRESCALE, d, r);
    chk({31'h0, d <= 32'h1}, 32'h1);
    k = 0;
    while (lvl_a !== 1'b0 && k < 100) begin @(posedge aclk); k++; end
    rd(pwm_pkg::OFF_FIRST, d, r);
    chk({31'h0, d <= 32'h3}, 32'h1);
    wr(pwm_pkg::OFF_SECOND, 32'h0);
    wr(pwm_pkg::OFF_FIRST, 32'h0);
    rc(pwm_pkg::OFF_SECOND, 32'h0);
    meas(hi, lo);
    chk({16'h0, hi, lo}, 32'h0002_0002);
    wr(pwm_pkg::OFF_CTRL, 32'h0);
    r0 = rises;
    repeat (30) @(posedge aclk);
    chk({16'h0, rises}, {16'h0, r0});
  endtask : t_update

  task automatic t_halt();
    logic [15:0] r0;
    setup(8'h00, 8'h03, 8'h03, 4'h0);
    wr(pwm_pkg::OFF_CTRL, 32'h2);
    // Halt may return the pin to the first-phase level two edges later
    repeat (3) @(posedge aclk);
    r0 = rises;
    repeat (30) @(posedge aclk);
    chk({16'h0, rises}, {16'h0, r0});
    rc(pwm_pkg::OFF_CTRL, 32'h0);
    rc(pwm_pkg::OFF_PRESCALE, 32'hff);
    rc(pwm_pkg::OFF_FIRST, 32'hff);
    rc(pwm_pkg::OFF_SECOND, 32'hff);
  endtask : t_halt

  task automatic t_pins();
    logic [15:0] hi, lo, r0;
    wr(pwm_pkg::OFF_PINROUTE, 32'h1);
    wr(pwm_pkg::OFF_PORTLATCH, 32'h1);
    setup(8'h00, 8'h01, 8'h01, 4'h2);
    r0 = rises;
    repeat (12) @(posedge aclk);
    chk({29'h0, lvl_b, pin_a_oe, pin_b_oe}, 32'h5);
    chk({16'h0, rises}, {16'h0, r0});
    wr(pwm_pkg::OFF_IOCTRL, 32'h0);
    meas(hi, lo);
    chk({16'h0, hi, lo}, 32'h0002_0002);
  endtask : t_pins

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sources();
    t_polarity();
    t_update();
    t_halt();
    t_pins();
    close_out();
  end

  // Whole run needs about a thousand cycles
  initial begin
    #3000000;
    num_errors++;
    close_out();
  end
endmodule : timer_waveform_gen_tb

bind timer_waveform_gen timer_waveform_monitor u_mon (.*);
`default_nettype wire
